// ### design/acor_regs.sv
`include "acor_defines.svh"

module acor_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire acor_pkg::acor_req_t req,
    output acor_pkg::acor_rsp_t rsp,
    input wire logic cal_done,
    input wire logic [15:0] cal_result,
    output acor_pkg::acor_ctrl_t ctrl,
    output logic cal_scan_enable,
    output logic [15:0] cal_value
);

    typedef struct packed {
        logic [15:0] cal_adj;
        logic [15:0] rsv_six;
        logic [15:0] des_adj;
        logic [15:0] rsv_eight;
        logic [15:0] rsv_nine;
        logic [15:0] ofs_adj;
        acor_pkg::acor_rsp_t rsp;
        acor_pkg::acor_ctrl_t ctrl;
        logic scan;
        logic [15:0] cal_mirror;
    } acor_state_t;

    acor_state_t s_q;
    acor_state_t s_d;
    acor_pkg::acor_cal_op_t cal_op;
    logic [15:0] cal_word;

    acor_cal_window #(
        .WIDTH(16)
    ) u_window (
        .sys_clk(sys_clk),
        .rst(rst),
        .op(cal_op),
        .host_word(req.wdata),
        .engine_word(cal_result),
        .value(cal_word)
    );

    always_comb begin
        cal_op = acor_pkg::ACOR_HOLD;
        if (req.wr && req.addr == `ACOR_ADDR_CAL_VAL && s_q.scan) begin
            cal_op = acor_pkg::ACOR_STORE;
        end else if (cal_done) begin
            cal_op = acor_pkg::ACOR_LOAD;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp.valid = 1'b0;
        if (req.wr) begin
            case (req.addr)
                `ACOR_ADDR_CAL_ADJ: begin
                    s_d.cal_adj = req.wdata;
                end
                `ACOR_ADDR_RSV_SIX: begin
                    s_d.rsv_six = req.wdata;
                end
                `ACOR_ADDR_DES_ADJ: begin
                    s_d.des_adj = req.wdata;
                end
                `ACOR_ADDR_RSV_EIGHT: begin
                    s_d.rsv_eight = req.wdata;
                end
                `ACOR_ADDR_RSV_NINE: begin
                    s_d.rsv_nine = req.wdata;
                end
                `ACOR_ADDR_OFS_ADJ: begin
                    s_d.ofs_adj = req.wdata;
                end
                default: begin
                    s_d.ofs_adj = s_d.ofs_adj;
                end
            endcase
        end
        if (req.rd) begin
            s_d.rsp.valid = 1'b1;
            case (req.addr)
                `ACOR_ADDR_CAL_ADJ: begin
                    s_d.rsp.rdata = s_q.cal_adj;
                end
                `ACOR_ADDR_CAL_VAL: begin
                    s_d.rsp.rdata = s_q.scan ? cal_word : 16'h0000;
                end
                `ACOR_ADDR_RSV_SIX: begin
                    s_d.rsp.rdata = s_q.rsv_six;
                end
                `ACOR_ADDR_DES_ADJ: begin
                    s_d.rsp.rdata = s_q.des_adj;
                end
                `ACOR_ADDR_RSV_EIGHT: begin
                    s_d.rsp.rdata = s_q.rsv_eight;
                end
                `ACOR_ADDR_RSV_NINE: begin
                    s_d.rsp.rdata = s_q.rsv_nine;
                end
                `ACOR_ADDR_OFS_ADJ: begin
                    s_d.rsp.rdata = s_q.ofs_adj;
                end
                default: begin
                    s_d.rsp.rdata = 16'h0000;
                end
            endcase
        end
        s_d.scan = s_d.cal_adj[`ACOR_SCAN_BIT];
        s_d.ctrl.dual_edge_timing_trim = s_d.des_adj[`ACOR_TRIM_MSB:`ACOR_TRIM_LSB];
        s_d.ctrl.duty_cycle_correct = 1'b1;
        s_d.ctrl.offset_polarity = s_d.ofs_adj[`ACOR_POL_BIT];
        // low three bits may not be monotonic; passed through as is
        s_d.ctrl.offset_magnitude = s_d.ofs_adj[`ACOR_MAG_MSB:`ACOR_MAG_LSB];
        s_d.cal_mirror = cal_word;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q.cal_adj <= `ACOR_RST_CAL_ADJ;
            s_q.rsv_six <= `ACOR_RST_RSV_SIX;
            s_q.des_adj <= `ACOR_RST_DES_ADJ;
            s_q.rsv_eight <= `ACOR_RST_RSV_EIGHT;
            s_q.rsv_nine <= `ACOR_RST_RSV_NINE;
            s_q.ofs_adj <= `ACOR_RST_OFS_ADJ;
            s_q.rsp <= '0;
            s_q.ctrl.dual_edge_timing_trim <= 7'h40;
            s_q.ctrl.offset_polarity <= 1'b0;
            s_q.ctrl.offset_magnitude <= 12'h000;
            s_q.ctrl.duty_cycle_correct <= 1'b1;
            s_q.scan <= 1'b0;
            s_q.cal_mirror <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp = s_q.rsp;
    assign ctrl = s_q.ctrl;
    assign cal_scan_enable = s_q.scan;
    assign cal_value = s_q.cal_mirror;

endmodule : acor_regs

// ### shared/acor_defines.svh
`ifndef ACOR_DEFINES_SVH
`define ACOR_DEFINES_SVH

`define ACOR_ADDR_CAL_ADJ 4'h4
`define ACOR_ADDR_CAL_VAL 4'h5
`define ACOR_ADDR_RSV_SIX 4'h6
`define ACOR_ADDR_DES_ADJ 4'h7
`define ACOR_ADDR_RSV_EIGHT 4'h8
`define ACOR_ADDR_RSV_NINE 4'h9
`define ACOR_ADDR_OFS_ADJ 4'hA

`define ACOR_RST_CAL_ADJ 16'hDB4B
`define ACOR_RST_RSV_SIX 16'h1C2E
`define ACOR_RST_DES_ADJ 16'h8142
`define ACOR_RST_RSV_EIGHT 16'h0F0F
`define ACOR_RST_RSV_NINE 16'h0000
`define ACOR_RST_OFS_ADJ 16'h0000
`define ACOR_RST_CAL_VAL 16'h0000

`define ACOR_SCAN_BIT 7
`define ACOR_TRIM_MSB 15
`define ACOR_TRIM_LSB 9
`define ACOR_POL_BIT 12
`define ACOR_MAG_MSB 11
`define ACOR_MAG_LSB 0
`define ACOR_OFS_RSV_MASK 16'hE000

`define ACOR_TRIM_STEP_FS 30
`define ACOR_MAG_FULL_UV 45000
`define ACOR_MONO_BITS 9

`endif

// ### shared/acor_pkg.sv
package acor_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } acor_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } acor_rsp_t;

    typedef struct packed {
        logic [6:0] dual_edge_timing_trim;
        logic offset_polarity;
        logic [11:0] offset_magnitude;
        logic duty_cycle_correct;
    } acor_ctrl_t;

    typedef enum logic [1:0] {
        ACOR_HOLD = 2'b00,
        ACOR_LOAD = 2'b01,
        ACOR_STORE = 2'b10
    } acor_cal_op_t;

endpackage : acor_pkg

// ### design/acor_cal_window.sv
`include "acor_defines.svh"

// holds the scanned calibration word; calibration engine and host share it
module acor_cal_window #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire acor_pkg::acor_cal_op_t op,
    input wire logic [WIDTH-1:0] host_word,
    input wire logic [WIDTH-1:0] engine_word,
    output logic [WIDTH-1:0] value
);

    // the register map carries single 16-bit words only
    if (WIDTH != 16) begin : g_width_check
        $error("acor_cal_window: width must be 16");
    end

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } acor_win_state_t;

    acor_win_state_t s_q;
    acor_win_state_t s_d;

    always_comb begin
        s_d = s_q;
        case (op)
            acor_pkg::ACOR_LOAD: begin
                s_d.word = engine_word;
            end
            acor_pkg::ACOR_STORE: begin
                s_d.word = host_word;
            end
            default: begin
                s_d.word = s_q.word;
            end
        endcase
    end

    // contents are undefined on power-up; zero is kept so sim stays clean
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q.word <= WIDTH'(`ACOR_RST_CAL_VAL);
        end else begin
            s_q <= s_d;
        end
    end

    assign value = s_q.word;

endmodule : acor_cal_window

// ### tb/acor_regs_monitor.sv
module acor_regs_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire acor_pkg::acor_req_t req,
    input wire acor_pkg::acor_rsp_t rsp,
    input wire logic cal_done,
    input wire logic [15:0] cal_result,
    input wire acor_pkg::acor_ctrl_t ctrl,
    input wire logic cal_scan_enable,
    input wire logic [15:0] cal_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire logic wr_a = req.wr && req.addr == 4'hA;
    wire logic wr_4 = req.wr && req.addr == 4'h4;
    wire logic lock = req.rd && req.addr == 4'h5 && !cal_scan_enable;
    AST_RD_ANSWER: assert property (req.rd |=> rsp.valid)
        else $error("read not answered");
    AST_SCAN_LOCK: assert property (lock |=> rsp.rdata == 16'h0000)
        else $error("locked window readable");
    AST_SCAN_BIT: assert property (wr_4 |=> cal_scan_enable == $past(req.wdata[7]))
        else $error("scan bit wrong");
    AST_TRIM: assert property (req.wr && req.addr == 4'h7 |=>
        ctrl.dual_edge_timing_trim == $past(req.wdata[15:9])) else $error("trim wrong");
    AST_POLARITY: assert property (wr_a |=> ctrl.offset_polarity == $past(req.wdata[12]))
        else $error("polarity wrong");
    AST_MAGNITUDE: assert property (wr_a |=> ctrl.offset_magnitude == $past(req.wdata[11:0]))
        else $error("magnitude wrong");
    AST_DCC_ON: assert property (ctrl.duty_cycle_correct)
        else $error("duty correction off");
    // load lands in the window, then one more stage to the port
    AST_CAL_LOAD: assert property (cal_done && !req.wr |-> ##2 cal_value == $past(cal_result, 2))
        else $error("calibration word lost");
    C_WRITE_OFS: cover property (wr_a);
    C_CAL_READ: cover property (req.rd && req.addr == 4'h5 && cal_scan_enable);
    C_CAL_DONE: cover property (cal_done);
endmodule : acor_regs_monitor

// ### tb/acor_host.sv
module acor_host (
    input wire logic sys_clk,
    input wire acor_pkg::acor_rsp_t rsp,
    output acor_pkg::acor_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        if (a == 4'hA) d[15:13] = 3'h0;
        if (a == 4'h7) d[8:0] = 9'h142;
        @(posedge sys_clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        // released data is inverted so a stale bus cannot pass
        #1 req.wr = 1'b0;
        req.wdata = ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge sys_clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(posedge sys_clk);
        #1 req.rd = 1'b0;
        for (int i = 0; i < 4 && rsp.valid !== 1'b1; i++) @(posedge sys_clk) #1;
        if (rsp.valid !== 1'b1) begin
            testbench.num_errors++;
            testbench.give_verdict();
        end
        q = rsp.rdata;
    endtask : rd
endmodule : acor_host

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cal_done = 1'b0;
    logic [15:0] cal_result = 16'h0000;
    logic [15:0] got;
    logic [15:0] mdl [16];
    int num_errors = 0;
    int n_compared = 0;
    acor_pkg::acor_req_t req;
    acor_pkg::acor_rsp_t rsp;
    acor_pkg::acor_ctrl_t ctrl;
    logic cal_scan_enable;
    logic [15:0] cal_value;
    always #4 sys_clk = ~sys_clk;
    acor_regs u_acor_regs (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
        .cal_done(cal_done), .cal_result(cal_result), .ctrl(ctrl),
        .cal_scan_enable(cal_scan_enable), .cal_value(cal_value));
    acor_host u_acor_host (.sys_clk(sys_clk), .rsp(rsp), .req(req));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    function automatic logic ok(input logic [3:0] a);
        return a > 4'h3 && a < 4'hB && (a != 4'h5 || mdl[4][7]);
    endfunction : ok
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        u_acor_host.wr(a, d);
        if (ok(a)) mdl[a] = d;
    endtask : put
    task automatic look(input logic [3:0] a);
        u_acor_host.rd(a, got);
        check(got, ok(a) ? mdl[a] : 16'h0000);
    endtask : look
    initial begin
        mdl = '{4: 16'hDB4B, 6: 16'h1C2E, 7: 16'h8142, 8: 16'h0F0F, default: 16'h0000};
        void'($urandom(32'h29FECFC0));
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int a = 0; a < 16; a++) look(4'(a));
        put(4'h5, 16'h1234);
        put(4'hF, 16'hFFFF);
        look(4'h5);
        check({15'h0000, cal_scan_enable}, 16'h0000);
        put(4'h4, 16'hDBCB);
        check({15'h0000, cal_scan_enable}, 16'h0001);
        check({15'h0000, ctrl.duty_cycle_correct}, 16'h0001);
        repeat (4) begin
            put(4'h5, 16'($urandom));
            look(4'h5);
            put(4'h7, {7'($urandom), 9'h142});
            check({9'h000, ctrl.dual_edge_timing_trim}, {9'h000, mdl[7][15:9]});
            put(4'hA, 16'($urandom) & 16'h1FFF);
            check({3'h0, ctrl.offset_polarity, ctrl.offset_magnitude}, mdl[10]);
            @(posedge sys_clk);
            #1 cal_done = 1'b1;
            cal_result = 16'($urandom);
            mdl[5] = cal_result;
            @(posedge sys_clk);
            #1 cal_done = 1'b0;
            look(4'h5);
            check(cal_value, mdl[5]);
        end
        put(4'h4, 16'hDB4B);
        check({15'h0000, cal_scan_enable}, 16'h0000);
        for (int a = 0; a < 16; a++) look(4'(a));
        give_verdict();
    end
endmodule : testbench

bind acor_regs acor_regs_monitor u_acor_regs_monitor (.sys_clk(sys_clk), .rst(rst), .req(req),
    .rsp(rsp), .cal_done(cal_done), .cal_result(cal_result), .ctrl(ctrl),
    .cal_scan_enable(cal_scan_enable), .cal_value(cal_value));
